// ---- rtl/esm_pkg.sv ----
/*
  Package for the extended SMM memory control block: register offset,
  field positions, reset value, address windows and segment sizes.
  Assumes byte-wide configuration access at the documented offset.
*/
package esm_pkg;
  localparam int ADDR_W = 36;
  localparam logic [7:0] CFG_EXT_SMM_CTRL = 8'h9E;
  localparam logic [7:0] EXT_SMM_CTRL_RESET = 8'h38;
  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int BIT_HIGH_EN = 7;
  localparam int BIT_ERR = 6;
  localparam int BIT_SEG_EN = 0;
  localparam int BIT_SZ_LO = 1;
  localparam logic [7:0] FORCED_ONES = 8'h38;
  localparam logic [ADDR_W-1:0] HIGH_BASE = 36'h0_FEDA_0000;
  localparam logic [ADDR_W-1:0] HIGH_LAST = 36'h0_FEDB_FFFF;
  localparam logic [ADDR_W-1:0] LOW_BASE = 36'h0_000A_0000;
  localparam logic [ADDR_W-1:0] SIZE_1MB = 36'h0_0010_0000;
  localparam logic [ADDR_W-1:0] SIZE_2MB = 36'h0_0020_0000;
  localparam logic [ADDR_W-1:0] SIZE_8MB = 36'h0_0080_0000;
  localparam logic [ADDR_W-1:0] DRAM_LIMIT_256MB = 36'h0_1000_0000;
  localparam logic [1:0] SZ_1MB = 2'h0;
  localparam logic [1:0] SZ_2MB = 2'h1;
  localparam logic [1:0] SZ_8MB = 2'h2;
endpackage

// ---- rtl/esm_decode.sv ----
/*
  Combinational address decoder for the high SMM window and top segment.
  Assumes the controller's configuration bits are stable register outputs.
*/
`timescale 1ns/1ps
module esm_decode
  import esm_pkg::*;
(
  input wire logic [esm_pkg::ADDR_W-1:0] i_addr,
  input wire logic i_smm,
  input wire logic i_global_en,
  input wire logic i_high_en,
  input wire logic i_seg_en,
  input wire logic [1:0] i_seg_size,
  input wire logic i_open,
  input wire logic [esm_pkg::ADDR_W-1:0] i_low_dram_top,
  input wire logic [esm_pkg::ADDR_W-1:0] i_stolen_size,
  output logic o_hit_high,
  output logic o_hit_seg,
  output logic o_to_dram,
  output logic o_to_link,
  output logic o_invalid,
  output logic [esm_pkg::ADDR_W-1:0] o_dram_addr
);
  import esm_pkg::*;

  function automatic logic [ADDR_W-1:0] seg_bytes(input logic [1:0] sz);
    case (sz)
      SZ_1MB: seg_bytes = SIZE_1MB;
      SZ_2MB: seg_bytes = SIZE_2MB;
      SZ_8MB: seg_bytes = SIZE_8MB;
      default: seg_bytes = '0;
    endcase
  endfunction

  logic [ADDR_W-1:0] seg_top;
  logic [ADDR_W-1:0] seg_base;
  logic high_on;
  logic seg_on;
  logic allowed;

  always_comb begin
    seg_top = i_low_dram_top - i_stolen_size;
    seg_base = seg_top - seg_bytes(i_seg_size);
    high_on = i_global_en & i_high_en;
    seg_on = i_global_en & i_seg_en;
    o_hit_high = high_on && (i_addr >= HIGH_BASE) && (i_addr <= HIGH_LAST);
    o_hit_seg = seg_on && (i_addr >= seg_base) && (i_addr < seg_top);
    // open bit grants visibility outside smm
    allowed = i_smm | i_open;
    o_invalid = (o_hit_high | o_hit_seg) & ~i_smm & ~i_open;
    // remap only what goes to dram; the link keeps the cpu address
    o_dram_addr = (o_hit_high && allowed) ? (i_addr - HIGH_BASE + LOW_BASE) : i_addr;
    if (o_hit_high | o_hit_seg) begin
      o_to_dram = allowed;
    end else begin
      // reach capped at 256 mb while in use
      o_to_dram = (high_on | seg_on) ? (i_addr < DRAM_LIMIT_256MB) : 1'b1;
    end
    o_to_link = ~o_to_dram;
  end
endmodule

// ---- rtl/esm_ctrl.sv ----
/*
  Extended SMM memory control: the 8-bit control register on the
  configuration port, the lock and open bits of the neighbouring SMM
  register, and routing of processor requests to DRAM or the link.
  Assumes config accesses and requests are synchronous to i_clk_sys.
  Expects the lock and open strobes from the neighbouring register's decode.
*/
`timescale 1ns/1ps
module esm_ctrl
  import esm_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_rstn,
  input wire logic i_cfg_wr,
  input wire logic i_cfg_rd,
  input wire logic [7:0] i_cfg_addr,
  input wire logic [7:0] i_cfg_wdata,
  output logic [7:0] o_cfg_rdata,
  input wire logic i_trusted_mode,
  input wire logic i_global_smm_memory_enable,
  input wire logic i_smm_open_wr,
  input wire logic i_smm_open_val,
  input wire logic i_smm_lock_set,
  input wire logic i_req_valid,
  input wire logic i_req_smm,
  input wire logic [esm_pkg::ADDR_W-1:0] i_req_addr,
  input wire logic [esm_pkg::ADDR_W-1:0] i_low_dram_top,
  input wire logic [esm_pkg::ADDR_W-1:0] i_stolen_size,
  output logic o_smm_lock,
  output logic o_smm_open,
  output logic o_fwd_valid,
  output logic o_fwd_dram,
  output logic o_fwd_link,
  output logic [esm_pkg::ADDR_W-1:0] o_fwd_addr
);
  import esm_pkg::*;

  // ----------------------------------------------------------------
  // reset synchroniser
  // ----------------------------------------------------------------
  // assert at once, release on the clock: no flop leaves reset on a runt edge
  // only the second flop is read
  logic [1:0] rst_sync;
  logic rstn;
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rstn = rst_sync[1];

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  // cache bits are not stored: the read image forces them,
  // so no write can ever clear them
  typedef struct packed {
    logic high_smm_enable;
    logic invalid_smm_access_flag;
    logic [1:0] top_segment_size;
    logic seg_en;
    logic smm_lock;
    logic smm_open;
    logic [7:0] rdata;
    logic fwd_valid;
    logic fwd_dram;
    logic fwd_link;
    logic [ADDR_W-1:0] fwd_addr;
  } esm_state_t;

  esm_state_t st;
  esm_state_t next_st;

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  // decode is combinational on the raw request;
  // only the routed result is registered, one cycle later
  logic hit_high;
  logic hit_seg;
  logic to_dram;
  logic to_link;
  logic invalid;
  logic [ADDR_W-1:0] dram_addr;

  esm_decode i_esm_decode (
    .i_addr(i_req_addr),
    .i_smm(i_req_smm),
    .i_global_en(i_global_smm_memory_enable),
    .i_high_en(st.high_smm_enable),
    .i_seg_en(st.seg_en),
    .i_seg_size(st.top_segment_size),
    .i_open(st.smm_open),
    .i_low_dram_top(i_low_dram_top),
    .i_stolen_size(i_stolen_size),
    .o_hit_high(hit_high),
    .o_hit_seg(hit_seg),
    .o_to_dram(to_dram),
    .o_to_link(to_link),
    .o_invalid(invalid),
    .o_dram_addr(dram_addr)
  );

  // ----------------------------------------------------------------
  // register image
  // ----------------------------------------------------------------
  function automatic logic [7:0] reg_image(input esm_state_t s);
    logic [7:0] v;
    v = '0;
    v[BIT_HIGH_EN] = s.high_smm_enable;
    v[BIT_ERR] = s.invalid_smm_access_flag;
    v[BIT_SZ_LO +: 2] = s.top_segment_size;
    v[BIT_SEG_EN] = s.seg_en;
    reg_image = v | FORCED_ONES;
  endfunction

  // ----------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------
  logic wr_hit;
  logic rd_hit;
  logic locked;
  logic err_set;
  logic err_clr;

  always_comb begin
    next_st = st;
    wr_hit = i_cfg_wr && (i_cfg_addr == CFG_EXT_SMM_CTRL);
    rd_hit = i_cfg_rd && (i_cfg_addr == CFG_EXT_SMM_CTRL);
    // lock or trusted mode freezes the enable and size fields; the error flag still sets and clears
    locked = i_trusted_mode | st.smm_lock;
    if (wr_hit && !locked) begin
      next_st.high_smm_enable = i_cfg_wdata[BIT_HIGH_EN];
      next_st.top_segment_size = i_cfg_wdata[BIT_SZ_LO +: 2];
      next_st.seg_en = i_cfg_wdata[BIT_SEG_EN];
    end

    err_clr = wr_hit && i_cfg_wdata[BIT_ERR];
    err_set = i_req_valid && invalid;
    if (err_clr) begin
      next_st.invalid_smm_access_flag = 1'b0;
    end
    // set wins over a same-cycle clear
    // so an access racing the clear is never lost
    if (err_set) begin
      next_st.invalid_smm_access_flag = 1'b1;
    end

    // open writable only while unlocked
    // trusted mode freezes open as it freezes the fields
    if (i_smm_open_wr && !locked) begin
      next_st.smm_open = i_smm_open_val;
    end

    if (i_smm_lock_set) begin
      next_st.smm_lock = 1'b1;
      next_st.smm_open = 1'b0;
    end

    // zero outside a read, so a stale byte never looks like an answer
    next_st.rdata = '0;
    if (rd_hit) begin
      next_st.rdata = reg_image(st);
    end

    // route each request
    // the address is registered unqualified; consumers look at valid
    next_st.fwd_valid = i_req_valid;
    next_st.fwd_dram = i_req_valid & to_dram;
    next_st.fwd_link = i_req_valid & to_link;
    next_st.fwd_addr = dram_addr;
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk_sys or negedge rstn) begin
    if (!rstn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // every output comes straight from a flop,
  // so downstream timing starts at a clock edge
  assign o_cfg_rdata = st.rdata;
  assign o_smm_lock = st.smm_lock;
  assign o_smm_open = st.smm_open;
  assign o_fwd_valid = st.fwd_valid;
  assign o_fwd_dram = st.fwd_dram;
  assign o_fwd_link = st.fwd_link;
  assign o_fwd_addr = st.fwd_addr;
endmodule

// ---- dv/esm_ctrl_assertions.sv ----
/*
  Port checker for esm_ctrl.
  Assumes it is bound to esm_ctrl and sees only its ports.
*/
`timescale 1ns/1ps
module esm_chk
  import esm_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_rstn,
  input wire logic i_cfg_rd,
  input wire logic [7:0] i_cfg_addr,
  input wire logic [7:0] o_cfg_rdata,
  input wire logic i_trusted_mode,
  input wire logic i_smm_lock_set,
  input wire logic i_req_valid,
  input wire logic o_smm_lock,
  input wire logic o_smm_open,
  input wire logic o_fwd_valid,
  input wire logic o_fwd_dram,
  input wire logic o_fwd_link
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_rstn);
  a_fwd_answers: assert property (i_req_valid |=> o_fwd_valid)
    else $error("request not forwarded");
  a_fwd_spurious: assert property (!i_req_valid |=> !o_fwd_valid)
    else $error("forward without request");
  a_one_dest: assert property (o_fwd_valid |-> o_fwd_dram != o_fwd_link)
    else $error("forward destination not unique");
  a_rdata_quiet: assert property ((!i_cfg_rd || i_cfg_addr != CFG_EXT_SMM_CTRL)
    |=> o_cfg_rdata == 8'h00) else $error("read data not zero");
  a_cache_ones: assert property (i_cfg_rd && i_cfg_addr == CFG_EXT_SMM_CTRL
    |=> o_cfg_rdata[5:3] == 3'h7) else $error("cache bits not one");
  a_lock_sticky: assert property (o_smm_lock |=> o_smm_lock)
    else $error("lock cleared without reset");
  a_lock_open: assert property (o_smm_lock |-> !o_smm_open)
    else $error("open while locked");
  a_open_frozen: assert property (i_trusted_mode && !i_smm_lock_set
    |=> $stable(o_smm_open)) else $error("open moved in trusted mode");
endmodule
bind esm_ctrl esm_chk i_esm_chk (.*);

// ---- dv/esm_host.sv ----
/*
  Processor-side model issuing SMM-tagged requests.
  Assumes the bench calls issue; one request per call.
*/
`timescale 1ns/1ps
module esm_host
  import esm_pkg::*;
(
  input wire logic i_clk_sys,
  output logic o_req_valid,
  output logic o_req_smm,
  output logic [esm_pkg::ADDR_W-1:0] o_req_addr
);
  initial begin
    o_req_valid = 1'h0;
    o_req_smm = 1'h0;
    o_req_addr = '0;
  end
  task automatic issue(input logic [ADDR_W-1:0] a, input logic s);
    @(negedge i_clk_sys);
    o_req_valid = 1'h1;
    o_req_smm = s;
    o_req_addr = a;
    @(negedge i_clk_sys);
    o_req_valid = 1'h0;
    // idle lines show junk so a stale address never passes for a live one
    o_req_smm = ~s;
    o_req_addr = ~a;
  endtask
endmodule

// ---- dv/tb_esm_ctrl.sv ----
/*
  Self-checking bench for esm_ctrl with a processor model.
  Assumes the checker is bound in from its own file.
*/
`timescale 1ns/1ps
module tb_esm_ctrl;
  import esm_pkg::*;
  logic clk, rstn, cwr, crd, tm, ge, ow, ov, ls, rv, rs, lock, open, fv, fd, fl;
  logic [7:0] caddr, wd, rdata, v;
  logic [35:0] ra, fa, top, st, sz, b, r;
  logic [9:0] rq[$];
  logic [37:0] fq[$];
  bit rd_d;
  int n_errors, n_checks;
  esm_host i_esm_host (.i_clk_sys(clk), .o_req_valid(rv), .o_req_smm(rs), .o_req_addr(ra));
  esm_ctrl i_esm_ctrl (.i_clk_sys(clk), .i_rstn(rstn), .i_cfg_wr(cwr), .i_cfg_rd(crd),
    .i_cfg_addr(caddr), .i_cfg_wdata(wd), .o_cfg_rdata(rdata), .i_trusted_mode(tm),
    .i_global_smm_memory_enable(ge), .i_smm_open_wr(ow), .i_smm_open_val(ov),
    .i_smm_lock_set(ls), .i_req_valid(rv), .i_req_smm(rs), .i_req_addr(ra),
    .i_low_dram_top(top), .i_stolen_size(st), .o_smm_lock(lock), .o_smm_open(open),
    .o_fwd_valid(fv), .o_fwd_dram(fd), .o_fwd_link(fl), .o_fwd_addr(fa));
  initial begin
    clk = 1'h0;
    forever #2 clk = ~clk;
  end
  // ----------------------------------------------------------------
  // drivers and monitor
  // ----------------------------------------------------------------
  task automatic pulse(ref logic s);
    @(negedge clk);
    s = 1'h1;
    @(negedge clk);
    s = 1'h0;
  endtask
  task automatic wr(input logic [7:0] d);
    caddr = CFG_EXT_SMM_CTRL;
    wd = d;
    pulse(cwr);
  endtask
  task automatic rd(input logic [7:0] a, input logic [9:0] e);
    caddr = a;
    rq.push_back(e);
    pulse(crd);
  endtask
  task automatic req(input logic [35:0] a, input logic s, input logic [37:0] e);
    fq.push_back(e);
    i_esm_host.issue(a, s);
  endtask
  always @(posedge clk) rd_d <= crd;
  always @(negedge clk) begin
    if (rd_d) begin
      n_checks++;
      if ({lock, open, rdata} !== rq[0]) begin
        n_errors++;
        $display("FAIL %0t %h %h", $time, {lock, open, rdata}, rq[0]);
      end
      void'(rq.pop_front());
    end
    if (fv === 1'h1) begin
      n_checks++;
      if ({fd, fl, fa} !== fq[0]) begin
        n_errors++;
        $display("FAIL %0t %h %h", $time, {fd, fl, fa}, fq[0]);
      end
      void'(fq.pop_front());
    end
  end
  task automatic report_and_stop;
    n_errors += rq.size() + fq.size();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    #20000;
    n_errors++;
    report_and_stop();
  end
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial begin
    {rstn, cwr, crd, tm, ge, ow, ov, ls, caddr, wd} = 24'h0;
    top = 36'h0_1000_0000;
    st = 36'h0_0100_0000;
    void'($urandom(93));
    repeat (16) @(negedge clk);
    rstn = 1'h1;
    repeat (3) @(negedge clk);
    rd(CFG_EXT_SMM_CTRL, {2'h0, 8'h38});
    rd(8'h9D, 10'h000);
    ge = 1'h1;
    for (int z = 0; z < 3; z++) begin
      v = {2'h2, 3'h7, z[1:0], 1'h1};
      wr(v ^ 8'h38);
      rd(CFG_EXT_SMM_CTRL, {2'h0, v});
      sz = (z == 0) ? SIZE_1MB : (z == 1) ? SIZE_2MB : SIZE_8MB;
      b = top - st - sz;
      r = {4'h0, $urandom} % sz;
      req(b + r, 1'h1, {2'h2, b + r});
      req(b, 1'h0, {2'h1, b});
      req(b - 36'h1, 1'h0, {2'h2, b - 36'h1});
      req(top - st - 36'h1, 1'h0, {2'h1, top - st - 36'h1});
      rd(CFG_EXT_SMM_CTRL, {2'h0, v | 8'h40});
      wr(v);
      rd(CFG_EXT_SMM_CTRL, {2'h0, v | 8'h40});
      wr(v | 8'h40);
      rd(CFG_EXT_SMM_CTRL, {2'h0, v});
    end
    r = {4'h0, $urandom} % 36'h2_0000;
    req(HIGH_BASE + r, 1'h1, {2'h2, LOW_BASE + r});
    req(HIGH_LAST, 1'h1, {2'h2, LOW_BASE + 36'h1_FFFF});
    req(HIGH_LAST + 36'h1, 1'h1, {2'h1, HIGH_LAST + 36'h1});
    req(DRAM_LIMIT_256MB, 1'h1, {2'h1, DRAM_LIMIT_256MB});
    req(HIGH_BASE, 1'h0, {2'h1, HIGH_BASE});
    rd(CFG_EXT_SMM_CTRL, {2'h0, v | 8'h40});
    wr(v | 8'h40);
    ge = 1'h0;
    req(HIGH_BASE, 1'h1, {2'h2, HIGH_BASE});
    req(b, 1'h0, {2'h2, b});
    ge = 1'h1;
    ov = 1'h1;
    pulse(ow);
    req(HIGH_BASE, 1'h0, {2'h2, LOW_BASE});
    rd(CFG_EXT_SMM_CTRL, {2'h1, v});
    tm = 1'h1;
    wr(8'h00);
    ov = 1'h0;
    pulse(ow);
    rd(CFG_EXT_SMM_CTRL, {2'h1, v});
    tm = 1'h0;
    pulse(ls);
    wr(8'h00);
    ov = 1'h1;
    pulse(ow);
    rd(CFG_EXT_SMM_CTRL, {2'h2, v});
    rstn = 1'h0;
    @(negedge clk);
    rstn = 1'h1;
    repeat (3) @(negedge clk);
    rd(CFG_EXT_SMM_CTRL, {2'h0, 8'h38});
    wr(8'h3F);
    req(top - st - 36'h1, 1'h0, {2'h2, top - st - 36'h1});
    rd(CFG_EXT_SMM_CTRL, {2'h0, 8'h3F});
    repeat (4) @(negedge clk);
    report_and_stop();
  end
endmodule
